// ### verilog/sss_start_stop_select.sv
// Start/stop source selector: routes one of three command sources.
// Assumes all inputs synchronous to clock; one clock, sync reset.
// How it works
// - One of three sources, local/remote settings
// - Configured selector input overrides other selectors
// - Input low local, high remote
// - Otherwise register local/remote bit selects
// - Register bit resets to local
// - Settings take any code, default terminal
// - Keypad source: keypad commands only
// - Terminal source: terminal strip commands
// - Serial source: network commands
// - Keypad stop always works unless disabled
`timescale 1ns/10ps
`default_nettype none
`include "sss_defines.svh"

module sss_start_stop_select (
   // Clock and reset
   input  wire  logic                clock,
   input  wire  logic                reset_n,
   // Configuration settings
   input  wire  logic                cfg_write,
   input  wire  sss_pkg::sss_cfg_t   cfg_in,
   // Local/remote selector input and register write
   input  wire  logic                lr_input,
   input  wire  logic                ctrl_reg_write,
   input  wire  logic [7:0]          ctrl_reg_data,
   // Command sources
   input  wire  sss_pkg::sss_cmd_t   keypad_cmd,
   input  wire  sss_pkg::sss_cmd_t   terminal_cmd,
   input  wire  sss_pkg::sss_cmd_t   serial_cmd,
   // Outputs
   output logic                      start_cmd,
   output logic                      stop_cmd,
   output logic                      remote_active,
   output logic [1:0]                active_source,
   output logic                      lr_reg_bit,
   output sss_pkg::sss_cfg_t         cfg_out
);
   import sss_pkg::*;

   typedef struct packed {
      sss_cfg_t   cfg;
      logic       lr_bit;
      logic [1:0] active;
      logic       remote;
      logic       start;
      logic       stop;
   } sss_state_t;

   sss_state_t state;
   sss_state_t next_state;
   sss_cmd_t   selected_cmd;
   logic       use_remote;
   logic [1:0] source_now;

   function automatic logic [1:0] pick_source(input logic       remote,
                                              input sss_cfg_t   c);
      pick_source = remote ? c.remote_source : c.local_source;
   endfunction

   // Selector uses current settings so a change acts next cycle
   always_comb begin
      if (state.cfg.lr_input_configured) begin
         use_remote = lr_input;
      end else begin
         use_remote = state.lr_bit;
      end
      source_now = pick_source(use_remote, state.cfg);
   end

   sss_source_mux u_mux (
      .active_source (source_now),
      .keypad_cmd    (keypad_cmd),
      .terminal_cmd  (terminal_cmd),
      .serial_cmd    (serial_cmd),
      .selected_cmd  (selected_cmd)
   );

   always_comb begin
      next_state = state;
      if (cfg_write) begin
         next_state.cfg = cfg_in;
      end
      if (ctrl_reg_write) begin
         next_state.lr_bit = ctrl_reg_data[`SSS_LR_BIT_POS];
      end
      next_state.active = source_now;
      next_state.remote = use_remote;
      next_state.start  = selected_cmd.start;
      // Keypad stop overrides other sources unless disabled
      next_state.stop   = selected_cmd.stop |
                          (keypad_cmd.stop &
                           !state.cfg.keypad_stop_disable);
      // A stop must win over a simultaneous start for safety
      if (next_state.stop) begin
         next_state.start = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state.cfg.local_source        <= `SSS_LOCAL_SOURCE_RESET;
         state.cfg.remote_source       <= `SSS_REMOTE_SOURCE_RESET;
         state.cfg.lr_input_configured <= 1'b0;
         state.cfg.keypad_stop_disable <= 1'b0;
         state.lr_bit                  <= `SSS_LR_BIT_RESET;
         state.active                  <= `SSS_TERMINAL_SOURCE_CODE;
         state.remote                  <= 1'b0;
         state.start                   <= 1'b0;
         state.stop                    <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   assign start_cmd     = state.start;
   assign stop_cmd      = state.stop;
   assign remote_active = state.remote;
   assign active_source = state.active;
   assign lr_reg_bit    = state.lr_bit;
   assign cfg_out       = state.cfg;

endmodule // sss_start_stop_select

`default_nettype wire

// ### verilog/sss_defines.svh
// Constants for the start/stop source selector.
// Assumes inclusion by bare name from the package and design modules.
`ifndef SSS_DEFINES_SVH
`define SSS_DEFINES_SVH

// Source setting encodings
`define SSS_KEYPAD_SOURCE_CODE    2'h0
`define SSS_TERMINAL_SOURCE_CODE  2'h1
`define SSS_SERIAL_SOURCE_CODE    2'h2

// Reset values
`define SSS_LOCAL_SOURCE_RESET    `SSS_TERMINAL_SOURCE_CODE
`define SSS_REMOTE_SOURCE_RESET   `SSS_TERMINAL_SOURCE_CODE
`define SSS_LR_BIT_RESET          1'h0

// Bit position of local/remote in the starter control register
`define SSS_LR_BIT_POS            0

`endif

// ### verilog/sss_pkg.sv
// Types for the start/stop source selector.
// Assumes sss_defines.svh on the include path.
`default_nettype none
`include "sss_defines.svh"

package sss_pkg;

   typedef enum logic [1:0] {
      SSS_SRC_KEYPAD   = `SSS_KEYPAD_SOURCE_CODE,
      SSS_SRC_TERMINAL = `SSS_TERMINAL_SOURCE_CODE,
      SSS_SRC_SERIAL   = `SSS_SERIAL_SOURCE_CODE
   } sss_source_t;

   // One start/stop command pair from a source
   typedef struct packed {
      logic start;
      logic stop;
   } sss_cmd_t;

   // Configuration settings
   typedef struct packed {
      logic [1:0] local_source;
      logic [1:0] remote_source;
      logic       lr_input_configured;
      logic       keypad_stop_disable;
   } sss_cfg_t;

endpackage : sss_pkg

`default_nettype wire

// ### verilog/sss_source_mux.sv
// Combinational selector: picks one source's start/stop commands.
// Assumes source codes from sss_defines.svh; illegal codes give no command.
`timescale 1ns/10ps
`default_nettype none
`include "sss_defines.svh"

module sss_source_mux (
   // Active source setting
   input  wire  logic [1:0]       active_source,
   // Source commands
   input  wire  sss_pkg::sss_cmd_t keypad_cmd,
   input  wire  sss_pkg::sss_cmd_t terminal_cmd,
   input  wire  sss_pkg::sss_cmd_t serial_cmd,
   // Selected command
   output var   sss_pkg::sss_cmd_t selected_cmd
);
   import sss_pkg::*;

   always_comb begin
      unique case (active_source)
         `SSS_KEYPAD_SOURCE_CODE:   selected_cmd = keypad_cmd;
         `SSS_TERMINAL_SOURCE_CODE: selected_cmd = terminal_cmd;
         `SSS_SERIAL_SOURCE_CODE:   selected_cmd = serial_cmd;
         // Code 3 is unused; refusing commands is the safe choice
         default:                   selected_cmd = '0;
      endcase
   end

endmodule // sss_source_mux

`default_nettype wire

// ### sim/sss_src_model.sv
// Stand-in for keypad, terminal strip and network link.
// Assumes press is {keypad, terminal, serial}, each {start, stop}.
`timescale 1ns/10ps
`default_nettype none
module sss_src_model (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        reset_n,
   // Requested presses and resulting commands
   input  wire logic [5:0]  press,
   output var  sss_pkg::sss_cmd_t keypad_cmd, terminal_cmd, serial_cmd
);
   import sss_pkg::*;
   // Commands land a clock late, as a debounced contact would
   always_ff @(posedge clock)
      if (!reset_n) {keypad_cmd, terminal_cmd, serial_cmd} <= 6'h00;
      else {keypad_cmd, terminal_cmd, serial_cmd} <= press;
endmodule // sss_src_model
`default_nettype wire

// ### sim/sss_start_stop_select_assertions.sv
// Port checks for the start/stop source selector.
// Sees only top ports; bound after the module.
`timescale 1ns/10ps
`default_nettype none
module sss_start_stop_select_assertions (
   // Inputs
   input wire logic clock, reset_n, cfg_write, lr_input, ctrl_reg_write,
   input wire logic [7:0] ctrl_reg_data,
   input wire sss_pkg::sss_cfg_t cfg_in,
   input wire sss_pkg::sss_cmd_t keypad_cmd, terminal_cmd, serial_cmd,
   // Outputs
   input wire logic start_cmd, stop_cmd, remote_active, lr_reg_bit,
   input wire logic [1:0] active_source,
   input wire sss_pkg::sss_cfg_t cfg_out
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   a_reset_vals: assert property ($rose(reset_n) |->
      cfg_out == 6'h14 && !lr_reg_bit) else $error("reset values");
   a_cfg_load: assert property (cfg_write |=>
      cfg_out == $past(cfg_in)) else $error("cfg load");
   a_lr_store: assert property (ctrl_reg_write |=>
      lr_reg_bit == $past(ctrl_reg_data[0])) else $error("lr store");
   a_pin_select: assert property (cfg_out.lr_input_configured |=>
      remote_active == $past(lr_input)) else $error("pin select");
   a_bit_select: assert property (!cfg_out.lr_input_configured |=>
      remote_active == $past(lr_reg_bit)) else $error("bit select");
   a_src_follow: assert property (1'b1 |=> active_source ==
      (remote_active ? $past(cfg_out.remote_source)
       : $past(cfg_out.local_source))) else $error("source follow");
   a_kp_stop: assert property (keypad_cmd.stop &&
      !cfg_out.keypad_stop_disable |=> stop_cmd) else $error("kp stop");
   a_start_src: assert property (start_cmd |-> !stop_cmd &&
      (active_source == 2'h0 ? $past(keypad_cmd.start)
       : active_source == 2'h1 ? $past(terminal_cmd.start)
       : $past(serial_cmd.start))) else $error("start source");
endmodule // sss_start_stop_select_assertions
bind sss_start_stop_select sss_start_stop_select_assertions
   sss_start_stop_select_assertions_inst (.*);
`default_nettype wire

// ### sim/sss_start_stop_select_tb.sv
// Self-checking bench for the start/stop source selector.
// Assumes the source model drives the three command inputs.
`timescale 1ns/10ps
`default_nettype none
module sss_start_stop_select_tb;
   import sss_pkg::*;
   logic clock = 1'b0, reset_n = 1'b0, cfg_write = 1'b0, lr_input = 1'b0;
   logic ctrl_reg_write = 1'b0;
   logic [7:0] ctrl_reg_data = 8'h00;
   logic [5:0] press = 6'h00;
   sss_cfg_t cfg_in = 6'h00, cfg_out;
   sss_cmd_t keypad_cmd, terminal_cmd, serial_cmd;
   logic start_cmd, stop_cmd, remote_active, lr_reg_bit;
   logic [1:0] active_source;
   int err_count = 0, total_checks = 0;
   always #10 clock = ~clock;
   sss_start_stop_select sss_start_stop_select_inst (.*);
   sss_src_model sss_src_model_inst (.*);
   task chk(input string n, input logic [5:0] e, g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task test_done;
      if (err_count == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // One setting change plus one press; bl is {register bit, pin}
   task t(input logic [5:0] c, input logic [1:0] bl, input logic [5:0] p,
          input logic [1:0] e);
      logic r;
      // Pin decides when configured, otherwise the register bit
      r = c[1] ? bl[0] : bl[1];
      @(posedge clock);
      cfg_in <= c;
      cfg_write <= 1'b1;
      ctrl_reg_data <= {7'h00, bl[1]};
      ctrl_reg_write <= 1'b1;
      lr_input <= bl[0];
      press <= p;
      @(posedge clock);
      cfg_write <= 1'b0;
      ctrl_reg_write <= 1'b0;
      repeat (2) @(posedge clock);
      #1 chk("start_stop", {4'h0, e}, {4'h0, start_cmd, stop_cmd});
      chk("source", {3'h0, r, r ? c[3:2] : c[5:4]},
          {3'h0, remote_active, active_source});
      @(posedge clock);
      press <= 6'h00;
      repeat (3) @(posedge clock);
   endtask
   initial begin
      repeat (12) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      #1 chk("cfg_out", 6'h14, cfg_out);
      chk("lr_reg_bit", 6'h00, {5'h00, lr_reg_bit});
      t(6'h14, 2'h0, 6'h0A, 2'h2);
      t(6'h14, 2'h0, 6'h02, 2'h0);
      t(6'h14, 2'h0, 6'h10, 2'h1);
      t(6'h15, 2'h0, 6'h10, 2'h0);
      t(6'h08, 2'h0, 6'h28, 2'h2);
      t(6'h08, 2'h0, 6'h08, 2'h0);
      t(6'h08, 2'h0, 6'h30, 2'h1);
      t(6'h08, 2'h2, 6'h02, 2'h2);
      t(6'h0A, 2'h2, 6'h02, 2'h0);
      t(6'h0A, 2'h2, 6'h20, 2'h2);
      t(6'h0A, 2'h1, 6'h02, 2'h2);
      test_done;
   end
   // Whole run needs about 2 us
   initial begin
      #5000;
      err_count++;
      test_done;
   end
endmodule // sss_start_stop_select_tb
`default_nettype wire
